// *** aifsr_pkg.sv ***
// Package of constants and types for the analog interface signal routing block
// Operation
// - Range select sets 5 V or 10 V reference
// - Standby input polarity normal or inverted
// - Off-only action: input only switches stage off
// - Auto action: off, then restore if previously on and analog remote not active
// - First alarm pin default: overtemperature OR power fail
// - First alarm pin selects three source options
// - Second alarm pin default: overvoltage only
// - Second alarm pin selects seven alarm combinations
// - Status pin shows regulation mode or DC state
package aifsr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] AIFSR_CFG_OFS = 12'h000;
  localparam logic [11:0] AIFSR_STAT_OFS = 12'h004;
  localparam logic [11:0] AIFSR_IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] AIFSR_IRQ_MASK_OFS = 12'h00C;
  // ****************************************
  // Configuration fields
  // ****************************************
  localparam int AIFSR_RANGE_BIT = 0;
  localparam int AIFSR_POL_BIT = 1;
  localparam int AIFSR_ACTION_BIT = 2;
  localparam int AIFSR_ALM1_LSB = 4;
  localparam int AIFSR_ALM2_LSB = 8;
  localparam int AIFSR_STSEL_BIT = 12;
  // Status fields
  localparam int AIFSR_ST_STANDBY_BIT = 0;
  localparam int AIFSR_ST_STAGE_BIT = 1;
  localparam int AIFSR_ST_ALM1_BIT = 2;
  localparam int AIFSR_ST_ALM2_BIT = 3;
  localparam int AIFSR_ST_STPIN_BIT = 4;
  // Interrupt events
  localparam int AIFSR_EV_STANDBY_ON = 0;
  localparam int AIFSR_EV_STANDBY_OFF = 1;
  localparam int AIFSR_EV_ALM1 = 2;
  localparam int AIFSR_EV_ALM2 = 3;
  localparam int AIFSR_EV_W = 4;
  // ****************************************
  // Selection encodings
  // ****************************************
  localparam logic [1:0] AIFSR_ALM1_OT = 2'h1;
  localparam logic [1:0] AIFSR_ALM1_PF = 2'h2;
  localparam logic [1:0] AIFSR_ALM1_BOTH = 2'h3;
  // Second alarm: bit0 overvoltage, bit1 overcurrent, bit2 overpower
  localparam logic [2:0] AIFSR_ALM2_OVP = 3'h1;
  // Reset values and configuration write mask
  localparam logic [31:0] AIFSR_CFG_RST = 32'h0000_0130;
  localparam logic [31:0] AIFSR_CFG_WMASK = 32'h0000_1777;
  localparam logic [3:0] AIFSR_MASK_RST = 4'h0;
  // AHB and reference select encodings
  localparam logic [1:0] AIFSR_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    AIFSR_REF_5V = 2'b00,
    AIFSR_REF_10V = 2'b01
  } aifsr_ref_t;
endpackage : aifsr_pkg

// *** aifsr_sync.sv ***
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module aifsr_sync (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  logic next_meta;
  logic next_q;
  always_comb begin
    next_meta = srst_in ? 1'b0 : d_in;
    next_q = srst_in ? 1'b0 : meta;
  end
  always_ff @(posedge mclk_in) begin
    meta <= next_meta;
    q_out <= next_q;
  end
endmodule : aifsr_sync

// *** aifsr_top.sv ***
// Analog interface signal routing with AHB-Lite register slave
`timescale 1ns/1ps
module aifsr_top (
  input wire logic mclk_in,
  input wire logic srst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Pin and status inputs
  input wire logic remote_standby_input_in,
  input wire logic overtemperature_alarm_in,
  input wire logic power_fail_alarm_in,
  input wire logic overvoltage_protection_alarm_in,
  input wire logic overcurrent_protection_alarm_in,
  input wire logic overpower_protection_alarm_in,
  input wire logic constant_voltage_regulation_in,
  input wire logic analog_remote_active_in,
  input wire logic stage_on_request_in,
  input wire logic stage_off_request_in,
  // Outputs
  output logic [1:0] reference_select_out,
  output logic dc_stage_on_out,
  output logic alarm1_pin_out,
  output logic alarm2_pin_out,
  output logic status_pin_out,
  output logic irq_out
);
  import aifsr_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [9:0] raw_in;
  logic [9:0] sync_q;
  assign raw_in = {stage_off_request_in, stage_on_request_in, analog_remote_active_in,
                   constant_voltage_regulation_in, overpower_protection_alarm_in,
                   overcurrent_protection_alarm_in, overvoltage_protection_alarm_in,
                   power_fail_alarm_in, overtemperature_alarm_in, remote_standby_input_in};
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_sync
      aifsr_sync u_sync (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .d_in(raw_in[gi]),
        .q_out(sync_q[gi])
      );
    end
  endgenerate

  logic sb_pin;
  logic ot_s;
  logic pf_s;
  logic ovp_s;
  logic ocp_s;
  logic opp_s;
  logic cv_s;
  logic ana_s;
  logic on_req_s;
  logic off_req_s;
  assign sb_pin = sync_q[0];
  assign ot_s = sync_q[1];
  assign pf_s = sync_q[2];
  assign ovp_s = sync_q[3];
  assign ocp_s = sync_q[4];
  assign opp_s = sync_q[5];
  assign cv_s = sync_q[6];
  assign ana_s = sync_q[7];
  assign on_req_s = sync_q[8];
  assign off_req_s = sync_q[9];

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] cfg;
  logic [AIFSR_EV_W-1:0] irq_stat;
  logic [AIFSR_EV_W-1:0] irq_mask;
  logic ap_valid;
  logic ap_write;
  logic [11:0] ap_addr;
  logic [31:0] next_cfg;
  logic [AIFSR_EV_W-1:0] next_irq_stat;
  logic [AIFSR_EV_W-1:0] next_irq_mask;
  logic next_ap_valid;
  logic next_ap_write;
  logic [11:0] next_ap_addr;
  logic [31:0] next_hrdata;

  logic range_10v;
  logic sb_invert;
  logic sb_auto;
  logic [1:0] alm1_sel;
  logic [2:0] alm2_sel;
  logic st_sel_dc;
  assign range_10v = cfg[AIFSR_RANGE_BIT];
  assign sb_invert = cfg[AIFSR_POL_BIT];
  assign sb_auto = cfg[AIFSR_ACTION_BIT];
  assign alm1_sel = cfg[AIFSR_ALM1_LSB +: 2];
  assign alm2_sel = cfg[AIFSR_ALM2_LSB +: 3];
  assign st_sel_dc = cfg[AIFSR_STSEL_BIT];

  // ****************************************
  // Standby and DC stage control
  // ****************************************
  logic sb_active;
  logic sb_prev;
  logic stage_on;
  logic restore_pend;
  logic next_sb_prev;
  logic next_stage_on;
  logic next_restore_pend;
  logic sb_rise;
  logic sb_fall;

  assign sb_active = sb_pin ^ sb_invert;
  assign sb_rise = sb_active & ~sb_prev;
  assign sb_fall = ~sb_active & sb_prev;

  always_comb begin
    next_sb_prev = sb_active;
    next_stage_on = stage_on;
    next_restore_pend = restore_pend;
    if (sb_active) begin
      if (sb_rise) begin
        next_restore_pend = stage_on & sb_auto & ~ana_s;
      end
      next_stage_on = 1'b0;
    end else if (off_req_s) begin
      next_stage_on = 1'b0;
      next_restore_pend = 1'b0;
    end else if (sb_fall && restore_pend && sb_auto && !ana_s) begin
      next_stage_on = 1'b1;
      next_restore_pend = 1'b0;
    end else if (on_req_s) begin
      next_stage_on = 1'b1;
    end
    if (srst_in) begin
      next_sb_prev = 1'b0;
      next_stage_on = 1'b0;
      next_restore_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    sb_prev <= next_sb_prev;
    stage_on <= next_stage_on;
    restore_pend <= next_restore_pend;
  end

  // ****************************************
  // Pin routing
  // ****************************************
  logic alm1_val;
  logic alm2_val;
  logic st_val;
  logic [1:0] ref_val;
  logic alm1_prev;
  logic alm2_prev;
  logic next_alm1_prev;
  logic next_alm2_prev;

  always_comb begin
    alm1_val = (alm1_sel[0] & ot_s) | (alm1_sel[1] & pf_s);
    alm2_val = (alm2_sel[0] & ovp_s) | (alm2_sel[1] & ocp_s) | (alm2_sel[2] & opp_s);
    st_val = st_sel_dc ? stage_on : cv_s;
    ref_val = range_10v ? AIFSR_REF_10V : AIFSR_REF_5V;
    next_alm1_prev = srst_in ? 1'b0 : alm1_val;
    next_alm2_prev = srst_in ? 1'b0 : alm2_val;
  end

  always_ff @(posedge mclk_in) begin
    alm1_prev <= next_alm1_prev;
    alm2_prev <= next_alm2_prev;
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic [1:0] next_ref_out;
  logic next_stage_out;
  logic next_alm1_out;
  logic next_alm2_out;
  logic next_st_out;
  logic next_irq;
  logic [AIFSR_EV_W-1:0] events;

  assign events = {alm2_val & ~alm2_prev, alm1_val & ~alm1_prev, sb_fall, sb_rise};

  always_comb begin
    next_ref_out = ref_val;
    next_stage_out = next_stage_on;
    next_alm1_out = alm1_val;
    next_alm2_out = alm2_val;
    next_st_out = st_val;
    next_irq = |(next_irq_stat & next_irq_mask);
    if (srst_in) begin
      next_ref_out = AIFSR_REF_5V;
      next_stage_out = 1'b0;
      next_alm1_out = 1'b0;
      next_alm2_out = 1'b0;
      next_st_out = 1'b0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    reference_select_out <= next_ref_out;
    dc_stage_on_out <= next_stage_out;
    alarm1_pin_out <= next_alm1_out;
    alarm2_pin_out <= next_alm2_out;
    status_pin_out <= next_st_out;
    irq_out <= next_irq;
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic [31:0] status_word;
  assign status_word = {27'h000_0000, st_val, alm2_val, alm1_val, stage_on, sb_active};

  always_comb begin
    next_ap_valid = hsel_in & hready_in & (htrans_in == AIFSR_HTRANS_NONSEQ);
    next_ap_write = hwrite_in;
    next_ap_addr = haddr_in[11:0];
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_hrdata = 32'h0000_0000;
    // Read of interrupt status clears, new events win
    if (next_ap_valid && !hwrite_in) begin
      if (haddr_in[11:0] == AIFSR_CFG_OFS) begin
        next_hrdata = cfg;
      end else if (haddr_in[11:0] == AIFSR_STAT_OFS) begin
        next_hrdata = status_word;
      end else if (haddr_in[11:0] == AIFSR_IRQ_STAT_OFS) begin
        next_hrdata = {28'h000_0000, irq_stat};
        next_irq_stat = '0;
      end else if (haddr_in[11:0] == AIFSR_IRQ_MASK_OFS) begin
        next_hrdata = {28'h000_0000, irq_mask};
      end
    end
    if (ap_valid && ap_write) begin
      if (ap_addr == AIFSR_CFG_OFS) begin
        next_cfg = hwdata_in & AIFSR_CFG_WMASK;
      end else if (ap_addr == AIFSR_IRQ_MASK_OFS) begin
        next_irq_mask = hwdata_in[AIFSR_EV_W-1:0];
      end
    end
    next_irq_stat = next_irq_stat | events;
    if (srst_in) begin
      next_ap_valid = 1'b0;
      next_ap_write = 1'b0;
      next_ap_addr = 12'h000;
      next_cfg = AIFSR_CFG_RST;
      next_irq_mask = AIFSR_MASK_RST;
      next_irq_stat = '0;
      next_hrdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_in) begin
    ap_valid <= next_ap_valid;
    ap_write <= next_ap_write;
    ap_addr <= next_ap_addr;
    cfg <= next_cfg;
    irq_mask <= next_irq_mask;
    irq_stat <= next_irq_stat;
    hrdata_out <= next_hrdata;
    hreadyout_out <= 1'b1;
    hresp_out <= 1'b0;
  end
endmodule : aifsr_top

// *** aifsr_ext_ctrl.sv ***
// Model of external control equipment driving the standby pin
`timescale 1ns/1ps
module aifsr_ext_ctrl (
  input wire logic mclk_in,
  input wire logic standby_req_in,
  input wire logic invert_in,
  output logic standby_pin_out
);
  initial standby_pin_out = 1'b0;
  // Pin level flips with inverted polarity
  always @(posedge mclk_in) begin
    standby_pin_out <= standby_req_in ^ invert_in;
  end
endmodule : aifsr_ext_ctrl

// *** aifsr_properties.sv ***
// Checker of pin routing and bus response relations
`timescale 1ns/1ps
module aifsr_checker (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic overtemperature_alarm_in,
  input wire logic power_fail_alarm_in,
  input wire logic overvoltage_protection_alarm_in,
  input wire logic overcurrent_protection_alarm_in,
  input wire logic overpower_protection_alarm_in,
  input wire logic stage_off_request_in,
  input wire logic [1:0] reference_select_out,
  input wire logic dc_stage_on_out,
  input wire logic alarm1_pin_out,
  input wire logic alarm2_pin_out,
  input wire logic irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  sequence s_alm1_idle;
    (!overtemperature_alarm_in && !power_fail_alarm_in) [*4];
  endsequence
  sequence s_alm2_idle;
    (!overvoltage_protection_alarm_in && !overcurrent_protection_alarm_in && !overpower_protection_alarm_in) [*4];
  endsequence
  sequence s_off_held;
    stage_off_request_in [*4];
  endsequence
  a_hready_high: assert property (hreadyout_out) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_out) else $error("error response");
  a_ref_legal: assert property (reference_select_out[1] == 1'b0) else $error("bad reference");
  a_alarm1_quiet: assert property (s_alm1_idle |-> !alarm1_pin_out) else $error("alarm1 stuck");
  a_alarm2_quiet: assert property (s_alm2_idle |-> !alarm2_pin_out) else $error("alarm2 stuck");
  a_off_priority: assert property (s_off_held |-> !dc_stage_on_out) else $error("stage not off");
  a_rdata_idle: assert property (!$past(hsel_in && hready_in && htrans_in == 2'h2 && !hwrite_in)
    |-> hrdata_out == 32'h0000_0000) else $error("stray read data");
  a_reset_clear: assert property (disable iff (1'b0) srst_in |=> !irq_out && !dc_stage_on_out
    && !alarm1_pin_out && reference_select_out == 2'h0) else $error("reset state");
endmodule : aifsr_checker

// *** tb_top.sv ***
// Self-checking bench for the analog interface signal routing block
`timescale 1ns/1ps
module tb_top;
  import aifsr_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] alm2 = 3'h0;
  logic ot = 1'b0, pf = 1'b0, cv = 1'b0, on_req = 1'b0, off_req = 1'b0, sb_req = 1'b0, sb_inv = 1'b0;
  logic ana = 1'b0;
  logic hrdy, hresp, sb_pin, stage, pin1, pin2, stpin, irq;
  logic [1:0] refsel;
  logic [31:0] hrdata, rd;
  int miscompares = 0;
  int checked = 0;
  aifsr_ext_ctrl u_aifsr_ext_ctrl (.mclk_in(mclk), .standby_req_in(sb_req), .invert_in(sb_inv),
    .standby_pin_out(sb_pin));
  aifsr_top u_aifsr_top (.mclk_in(mclk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .remote_standby_input_in(sb_pin),
    .overtemperature_alarm_in(ot), .power_fail_alarm_in(pf), .overvoltage_protection_alarm_in(alm2[0]),
    .overcurrent_protection_alarm_in(alm2[1]), .overpower_protection_alarm_in(alm2[2]),
    .constant_voltage_regulation_in(cv), .analog_remote_active_in(ana), .stage_on_request_in(on_req),
    .stage_off_request_in(off_req), .reference_select_out(refsel), .dc_stage_on_out(stage),
    .alarm1_pin_out(pin1), .alarm2_pin_out(pin2), .status_pin_out(stpin), .irq_out(irq));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic results;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    // Ready is taken as it stood at the rising edge
    do begin
      @(posedge mclk);
      n++;
    end while (hrdy !== 1'b1 && n < 100);
    if (hrdy !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= AIFSR_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask : settle
  task automatic pulse(input logic on);
    on_req <= on;
    off_req <= !on;
    @(posedge mclk);
    on_req <= 1'b0;
    off_req <= 1'b0;
  endtask : pulse
  task automatic t_regs;
    bus(0, AIFSR_CFG_OFS, 0); chk(rd === 32'h0000_0130, "cfg reset");
    bus(0, AIFSR_IRQ_MASK_OFS, 0); chk(rd === 32'h0000_0000, "mask reset");
    bus(1, 12'h040, 32'hFFFF_FFFF);
    bus(0, 12'h040, 0); chk(rd === 32'h0000_0000, "unmapped");
    for (int i = 0; i < 2; i++) begin
      bus(1, AIFSR_CFG_OFS, 32'h0000_0130 | 32'(i));
      settle();
      chk(refsel === (i == 1 ? 2'h1 : 2'h0), "range");
    end
  endtask : t_regs
  task automatic t_alarms;
    logic [9:0] k;
    for (int n = 0; n < 1024; n++) begin
      k = 10'(n);
      bus(1, AIFSR_CFG_OFS, {20'h0_0000, 1'b0, k[9:7], 2'h0, k[3:2], 4'h0});
      ot <= k[0];
      pf <= k[1];
      alm2 <= k[6:4];
      settle();
      chk(pin1 === |(k[3:2] & k[1:0]), "alarm1 routing");
      chk(pin2 === |(k[9:7] & k[6:4]), "alarm2 routing");
    end
    ot <= 1'b0;
    pf <= 1'b0;
    alm2 <= 3'h0;
    settle();
  endtask : t_alarms
  task automatic t_status;
    for (int k = 0; k < 8; k++) begin
      bus(1, AIFSR_CFG_OFS, 32'h0000_0130 | (k >= 4 ? 32'h0000_1000 : 32'h0000_0000));
      cv <= k[1];
      pulse(k[0]);
      settle();
      chk(stpin === (k >= 4 ? k[0] : k[1]), "status pin");
      bus(0, AIFSR_STAT_OFS, 0);
      chk(rd[AIFSR_ST_STPIN_BIT] === (k >= 4 ? k[0] : k[1]), "status word pin");
      chk(rd[AIFSR_ST_STAGE_BIT] === k[0], "status word stage");
    end
  endtask : t_status
  task automatic t_irq;
    bus(1, AIFSR_IRQ_MASK_OFS, 32'h0000_0004);
    bus(0, AIFSR_IRQ_STAT_OFS, 0);
    ot <= 1'b1;
    settle();
    chk(irq === 1'b1, "irq raised");
    bus(0, AIFSR_IRQ_STAT_OFS, 0); chk(rd[AIFSR_EV_ALM1] === 1'b1, "irq status");
    settle();
    chk(irq === 1'b0, "irq cleared");
    ot <= 1'b0;
    bus(1, AIFSR_IRQ_MASK_OFS, 32'h0000_0000);
    ot <= 1'b1;
    settle();
    chk(irq === 1'b0, "irq masked");
    bus(0, AIFSR_IRQ_STAT_OFS, 0); chk(rd[AIFSR_EV_ALM1] === 1'b1, "masked status");
    ot <= 1'b0;
  endtask : t_irq
  task automatic t_standby(input logic act, input logic inv);
    bus(1, AIFSR_CFG_OFS, 32'h0000_0130 | {29'h0, act, inv, 1'b0});
    sb_inv <= inv;
    settle();
    pulse(1'b1);
    settle();
    chk(stage === 1'b1, "stage on");
    sb_req <= 1'b1;
    settle();
    chk(stage === 1'b0, "standby off");
    sb_req <= 1'b0;
    settle();
    chk(stage === act, "standby release");
    pulse(1'b0);
    sb_req <= 1'b1;
    settle();
    sb_req <= 1'b0;
    settle();
    chk(stage === 1'b0, "no restore when off");
  endtask : t_standby
  task automatic t_remote;
    sb_inv <= 1'b0;
    ana <= 1'b1;
    bus(1, AIFSR_CFG_OFS, 32'h0000_0134);
    pulse(1'b1);
    settle();
    chk(stage === 1'b1, "remote stage on");
    sb_req <= 1'b1;
    settle();
    chk(stage === 1'b0, "remote standby off");
    sb_req <= 1'b0;
    settle();
    chk(stage === 1'b0, "no restore under remote");
    ana <= 1'b0;
    settle();
  endtask : t_remote
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_alarms();
    t_status();
    t_irq();
    for (int k = 0; k < 4; k++) t_standby(k[1], k[0]);
    t_remote();
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    bus(0, AIFSR_CFG_OFS, 0); chk(rd === 32'h0000_0130, "second reset");
    results();
  end
endmodule : tb_top
bind aifsr_top aifsr_checker u_aifsr_checker (.*);
